// [core/spme_consts.vh]
// Constants of the serial program mode entry block.
// Assumes inclusion by bare name from the design file.
`ifndef SPME_CONSTS_VH
`define SPME_CONSTS_VH
// ------------------------------------------------
// Widths and addresses
// ------------------------------------------------
`define SPME_CMD_W 6
`define SPME_WORD_W 14
`define SPME_ADDR_W 14
`define SPME_PC_RESET 14'h0000
`define SPME_ID_BASE 14'h2000
`define SPME_ID_LAST 14'h2003
`define SPME_CFG_ADDR 14'h2007
`define SPME_LVP_BIT 7
`define SPME_LVP_RESET 1'h1
`define SPME_FIFO_DEPTH 4
// ------------------------------------------------
// Command codes
// ------------------------------------------------
`define SPME_CMD_LOAD_CFG 6'h00
`define SPME_CMD_LOAD 6'h02
`define SPME_CMD_READ 6'h04
`define SPME_CMD_INC 6'h06
`endif

// [core/spme_prog_entry.v]
// Serial program mode entry: entry detection, command and word shifter, FIFO.
// Assumes pins arrive asynchronous, memory ports sit on the same clock.
//
// Behaviour
// - In program mode two former port pins become serial clock and data.
// - Program counter is zero on entry, before any command.
// - Each transaction starts with a six-bit command shifted in serially.
// - A 14-bit word follows: shifted in for load, out for read.
// - Low-voltage enable bit resets to one, enabling low-voltage entry.
// - While enabled, the entry pin is reserved, not general-purpose I/O.
// - With low-voltage enabled, a one on the entry pin enters program mode.
// - High voltage on master clear still enters program mode.
// - Cleared enable bit returns the entry pin to ordinary digital I/O.
// - Enable bit writable only in sessions entered by high voltage.
// - After the bit is zero, only high-voltage entry works.
// - User ID locations reachable only while in program mode.
// - Code protection makes program memory read back as zeros.
`timescale 1ns/1ps
`include "spme_consts.vh"

module spme_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = `SPME_FIFO_DEPTH,
  parameter AW = 2
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  input wire flush,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doWrite;
  wire doRead;

  assign inReady = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_ff];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always @(posedge clock)
  begin
    if (doWrite)
      mem[wrPtr_ff] <= inData;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWrite)
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      if (doRead)
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      if (doWrite && !doRead)
        count_ff <= count_ff + 1'b1;
      else if (doRead && !doWrite)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule

module spme_prog_entry (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Entry pins
  input wire highEntryLevel,
  input wire lowVoltageEntryPin,
  // Serial link
  input wire progClockPin,
  input wire progDataIn,
  output wire progDataOut,
  output wire progDataOe,
  // Entry pin as general I/O
  output wire entryPinReserved,
  output wire entryPinGpioIn,
  // Mode and status
  output wire progMode,
  output wire hvSession,
  output wire cpuReset,
  output wire userIdEnable,
  output wire lowVoltageProgEnable,
  output wire loadReady,
  output wire loadOverrun,
  // Memory write port
  output wire memWrValid,
  input wire memWrReady,
  output wire [`SPME_ADDR_W-1:0] memWrAddr,
  output wire [`SPME_WORD_W-1:0] memWrData,
  // Memory read port
  output wire [`SPME_ADDR_W-1:0] memRdAddr,
  input wire [`SPME_WORD_W-1:0] memRdData,
  input wire codeProtect
);
  localparam S_IDLE = 4'b0001;
  localparam S_CMD = 4'b0010;
  localparam S_LOAD = 4'b0100;
  localparam S_READ = 4'b1000;
  localparam CW = `SPME_CMD_W;
  localparam WW = `SPME_WORD_W;
  localparam AW = `SPME_ADDR_W;

  function inIdRange;
    input [AW-1:0] addr;
    begin
      inIdRange = (addr >= `SPME_ID_BASE) && (addr <= `SPME_ID_LAST);
    end
  endfunction

  // ------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  reg clkPrev_ff;
  wire hvIn = sync2_ff[0];
  wire lvIn = sync2_ff[1];
  wire clkIn = sync2_ff[2];
  wire datIn = sync2_ff[3];
  wire clkRise = clkIn && !clkPrev_ff;
  wire clkFall = !clkIn && clkPrev_ff;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      clkPrev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {progDataIn, progClockPin, lowVoltageEntryPin, highEntryLevel};
      sync2_ff <= sync1_ff;
      clkPrev_ff <= clkIn;
    end
  end

  // ------------------------------------------------
  // Entry and exit
  // ------------------------------------------------
  reg mode_ff;
  reg hv_ff;
  reg hvPrev_ff;
  reg lvp_ff;
  wire hvRise = hvIn && !hvPrev_ff;
  // Link pins must be low as master clear rises
  wire hvEntry = hvRise && !clkIn && !datIn;
  wire lvEntry = lvp_ff && lvIn && !hvIn;
  wire entryGone = hv_ff ? !hvIn : !lvIn;
  wire enter = !mode_ff && (hvEntry || lvEntry);
  wire leave = mode_ff && entryGone;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= 1'b0;
      hv_ff <= 1'b0;
      hvPrev_ff <= 1'b0;
    end
    else
    begin
      hvPrev_ff <= hvIn;
      if (enter)
      begin
        mode_ff <= 1'b1;
        hv_ff <= hvEntry;
      end
      else if (leave)
      begin
        mode_ff <= 1'b0;
        hv_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------
  // Command and word shifter
  // ------------------------------------------------
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [3:0] bitCnt_ff;
  reg [CW-1:0] cmd_ff;
  reg [WW-1:0] shift_ff;
  reg [AW-1:0] pc_ff;
  reg isCfg_ff;
  reg dataOut_ff;
  reg overrun_ff;
  wire fifoInReady;
  wire lastCmdBit = (bitCnt_ff == CW - 1);
  wire lastWordBit = (bitCnt_ff == WW - 1);
  wire [CW-1:0] cmdNow = {datIn, cmd_ff[CW-1:1]};
  wire [WW-1:0] wordNow = {datIn, shift_ff[WW-1:1]};
  wire wordDone = (state_ff == S_LOAD) && clkFall && lastWordBit;
  wire isProgMem = (pc_ff < `SPME_ID_BASE);
  wire [WW-1:0] readWord = (codeProtect && isProgMem) ? {WW{1'b0}} : memRdData;
  // Config word write keeps the enable bit unless high-voltage session
  wire cfgHit = (pc_ff == `SPME_CFG_ADDR);
  wire [WW-1:0] keptWord = (cfgHit && !hv_ff)
    ? ((wordNow & ~({{(WW-1){1'b0}}, 1'b1} << `SPME_LVP_BIT))
      | ({{(WW-1){1'b0}}, lvp_ff} << `SPME_LVP_BIT))
    : wordNow;

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (enter)
          nxt_state = S_CMD;
      S_CMD:
        if (clkFall && lastCmdBit)
        begin
          if (cmdNow == `SPME_CMD_LOAD || cmdNow == `SPME_CMD_LOAD_CFG)
            nxt_state = S_LOAD;
          else if (cmdNow == `SPME_CMD_READ)
            nxt_state = S_READ;
          else
            nxt_state = S_CMD;
        end
      S_LOAD:
        if (clkFall && lastWordBit)
          nxt_state = S_CMD;
      S_READ:
        if (clkFall && lastWordBit)
          nxt_state = S_CMD;
      default:
        nxt_state = S_IDLE;
    endcase
    if (leave)
      nxt_state = S_IDLE;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= S_IDLE;
      bitCnt_ff <= 4'h0;
      cmd_ff <= {CW{1'b0}};
      shift_ff <= {WW{1'b0}};
      pc_ff <= `SPME_PC_RESET;
      isCfg_ff <= 1'b0;
      dataOut_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (enter || leave)
      begin
        pc_ff <= `SPME_PC_RESET;
        bitCnt_ff <= 4'h0;
        isCfg_ff <= 1'b0;
        overrun_ff <= 1'b0;
        dataOut_ff <= 1'b0;
      end
      else if (state_ff == S_CMD && clkFall)
      begin
        cmd_ff <= cmdNow;
        if (lastCmdBit)
        begin
          bitCnt_ff <= 4'h0;
          if (cmdNow == `SPME_CMD_INC)
            pc_ff <= pc_ff + 1'b1;
          else if (cmdNow == `SPME_CMD_LOAD_CFG && !isCfg_ff)
          begin
            pc_ff <= `SPME_ID_BASE;
            isCfg_ff <= 1'b1;
          end
          else if (cmdNow == `SPME_CMD_READ)
            shift_ff <= readWord;
        end
        else
          bitCnt_ff <= bitCnt_ff + 1'b1;
      end
      else if (state_ff == S_LOAD && clkFall)
      begin
        shift_ff <= wordNow;
        bitCnt_ff <= lastWordBit ? 4'h0 : bitCnt_ff + 1'b1;
        if (wordDone && !fifoInReady)
          overrun_ff <= 1'b1;
      end
      else if (state_ff == S_READ)
      begin
        // Drive on rising edge, programmer samples on falling
        if (clkRise)
          dataOut_ff <= shift_ff[0];
        if (clkFall)
        begin
          shift_ff <= {1'b0, shift_ff[WW-1:1]};
          bitCnt_ff <= lastWordBit ? 4'h0 : bitCnt_ff + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------
  // Low-voltage enable bit
  // ------------------------------------------------
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lvp_ff <= `SPME_LVP_RESET;
    else if (wordDone && fifoInReady && cfgHit && hv_ff)
      lvp_ff <= wordNow[`SPME_LVP_BIT];
  end

  // ------------------------------------------------
  // Load word FIFO
  // ------------------------------------------------
  spme_fifo #(
    .WIDTH(AW + WW),
    .DEPTH(`SPME_FIFO_DEPTH),
    .AW(2)
  ) spme_fifo_inst (
    .clock(clock),
    .rst_n(rst_n),
    .flush(leave),
    .inValid(wordDone),
    .inReady(fifoInReady),
    .inData({pc_ff, keptWord}),
    .outValid(memWrValid),
    .outReady(memWrReady),
    .outData({memWrAddr, memWrData})
  );

  // ------------------------------------------------
  // Outputs
  // ------------------------------------------------
  assign progMode = mode_ff;
  assign hvSession = hv_ff;
  assign cpuReset = mode_ff;
  assign userIdEnable = mode_ff && inIdRange(pc_ff);
  assign progDataOut = dataOut_ff;
  assign progDataOe = mode_ff && (state_ff == S_READ);
  assign memRdAddr = pc_ff;
  assign lowVoltageProgEnable = lvp_ff;
  assign entryPinReserved = lvp_ff;
  assign entryPinGpioIn = lvp_ff ? 1'b0 : lvIn;
  assign loadReady = fifoInReady;
  assign loadOverrun = overrun_ff;
endmodule

// [sim/spme_prog_entry_properties.sv]
// Checker for the program mode entry block, bound to its ports.
// Assumes one clock domain with async active-low reset.
`timescale 1ns/1ps
`include "spme_consts.vh"
module spme_prog_entry_checker (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Watched ports
  input wire highEntryLevel,
  input wire lowVoltageEntryPin,
  input wire progDataOe,
  input wire entryPinReserved,
  input wire entryPinGpioIn,
  input wire progMode,
  input wire hvSession,
  input wire cpuReset,
  input wire userIdEnable,
  input wire lowVoltageProgEnable,
  input wire memWrValid,
  input wire memWrReady,
  input wire [`SPME_ADDR_W-1:0] memWrAddr,
  input wire [`SPME_ADDR_W-1:0] memRdAddr
);
  // ------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence lvHeld;
    (lowVoltageProgEnable && lowVoltageEntryPin && !highEntryLevel) [*8];
  endsequence
  sequence lvOff;
    (!lowVoltageProgEnable && !highEntryLevel) [*8];
  endsequence
  sequence hvGone;
    (progMode && hvSession) ##1 (!highEntryLevel) [*8];
  endsequence
  AST_CORE_HELD: assert property (cpuReset == progMode)
    else $error("core reset differs from program mode");
  AST_OE_IN_MODE: assert property (progDataOe |-> progMode)
    else $error("data line driven outside program mode");
  AST_PIN_RESERVED: assert property (entryPinReserved == lowVoltageProgEnable)
    else $error("entry pin reservation differs from enable bit");
  AST_GPIO_BLOCKED: assert property (entryPinReserved |-> !entryPinGpioIn)
    else $error("reserved entry pin seen by port logic");
  AST_PC_ZERO: assert property ($rose(progMode) |-> memRdAddr == `SPME_PC_RESET)
    else $error("counter not zero on entry");
  AST_USER_ID: assert property (userIdEnable == (progMode && memRdAddr >= `SPME_ID_BASE
    && memRdAddr <= `SPME_ID_LAST))
    else $error("user id window wrong");
  AST_LV_ENTRY: assert property (lvHeld |-> progMode)
    else $error("no entry on low-voltage pin");
  AST_LV_LOCKED: assert property (lvOff |-> !progMode)
    else $error("program mode without high level");
  AST_HV_EXIT: assert property (hvGone |-> !progMode)
    else $error("program mode kept after high level left");
  AST_WR_HOLD: assert property (memWrValid && !memWrReady && progMode ##1 progMode
    |-> memWrValid && $stable(memWrAddr))
    else $error("write request dropped before taken");
endmodule
bind spme_prog_entry spme_prog_entry_checker spme_prog_entry_checker_inst (.*);

// [sim/spme_prog_entry_tb_top.sv]
// Bench for the program mode entry block: both sessions, loads, reads, FIFO.
// Assumes the programmer model and the checker compile alongside.
`timescale 1ns/1ps
`include "spme_consts.vh"
module spme_prog_entry_tb_top;
  // ------------------------------------------------
  // Signals, instances, shared tasks
  // ------------------------------------------------
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg memWrReady = 1'b0;
  reg codeProtect = 1'b0;
  wire progClockPin, pgData, highEntryLevel, lowVoltageEntryPin, progDataOut, progDataOe;
  wire progDataIn = progDataOe ? progDataOut : pgData;
  wire progMode, hvSession, cpuReset, userIdEnable, lowVoltageProgEnable, loadReady;
  wire loadOverrun, memWrValid, entryPinReserved, entryPinGpioIn;
  wire [13:0] memWrAddr, memWrData, memRdAddr;
  wire [13:0] memRdData = memRdAddr ^ 14'h2A5C;
  integer err_total = 0;
  integer checks_done = 0;
  integer seed = 25;
  integer i;
  reg [31:0] rnd;
  reg [13:0] w;
  reg [27:0] expQ [$];
  always #2 clock = ~clock;
  spme_programmer spme_programmer_inst (.*);
  spme_prog_entry spme_prog_entry_inst (.*);
  task automatic check(input string name, input [27:0] seen, input [27:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic waitMode(input bit v);
    int k;
    for (k = 0; k < 60 && progMode !== v; k++) @(posedge clock);
  endtask
  task automatic load(input [5:0] c, input [13:0] d, input [13:0] a, input [13:0] e);
    expQ.push_back({a, e});
    spme_programmer_inst.sendCmd(c);
    spme_programmer_inst.sendWord(d);
  endtask
  task automatic cfgWrite(input [13:0] d, input [13:0] e);
    int k;
    load(`SPME_CMD_LOAD_CFG, 14'h1234, `SPME_ID_BASE, 14'h1234);
    check("id window", userIdEnable, 1'b1);
    for (k = 0; k < 7; k++) spme_programmer_inst.sendCmd(`SPME_CMD_INC);
    load(`SPME_CMD_LOAD, d, `SPME_CFG_ADDR, e);
    repeat (8) @(posedge clock);
  endtask
  task automatic readCheck(input string name, input [13:0] e);
    spme_programmer_inst.sendCmd(`SPME_CMD_READ);
    spme_programmer_inst.getWord(w);
    check(name, w, e);
  endtask
  always @(posedge clock)
  begin
    if (memWrValid === 1'b1 && memWrReady === 1'b1)
      check("memory write", {memWrAddr, memWrData}, expQ.size() ? expQ.pop_front() : 'x);
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    err_total = err_total + 1;
    give_verdict;
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    check("reset state", {lowVoltageProgEnable, entryPinReserved, progMode}, 3'b110);
    memWrReady <= 1'b1;
    spme_programmer_inst.setEntry(1'b0, 1'b1);
    waitMode(1'b1);
    check("lv entry", {progMode, hvSession, memRdAddr}, {2'b10, `SPME_PC_RESET});
    cfgWrite(14'h0000, 14'h0080);
    check("lv keeps enable", lowVoltageProgEnable, 1'b1);
    spme_programmer_inst.setEntry(1'b0, 1'b0);
    waitMode(1'b0);
    check("lv exit", {progMode, memRdAddr}, {1'b0, `SPME_PC_RESET});
    memWrReady <= 1'b0;
    spme_programmer_inst.setEntry(1'b1, 1'b0);
    waitMode(1'b1);
    check("hv entry", {hvSession, memRdAddr}, {1'b1, `SPME_PC_RESET});
    for (i = 0; i < 5; i++)
    begin
      rnd = $random(seed);
      load(`SPME_CMD_LOAD, rnd[13:0], i[13:0], rnd[13:0]);
      spme_programmer_inst.sendCmd(`SPME_CMD_INC);
      if (i == 3)
        check("fifo full", loadReady, 1'b0);
    end
    void'(expQ.pop_back());
    check("overrun", loadOverrun, 1'b1);
    memWrReady <= 1'b1;
    for (i = 0; i < 50 && expQ.size() > 0; i++) @(posedge clock);
    check("fifo drained", expQ.size() == 0, 1'b1);
    readCheck("read word", 14'h0005 ^ 14'h2A5C);
    codeProtect <= 1'b1;
    readCheck("protected read", 14'h0000);
    codeProtect <= 1'b0;
    spme_programmer_inst.sendCmd(6'h3F);
    readCheck("after unknown", 14'h0005 ^ 14'h2A5C);
    cfgWrite(14'h0000, 14'h0000);
    check("hv clears enable", {lowVoltageProgEnable, entryPinReserved}, 2'b00);
    spme_programmer_inst.setEntry(1'b0, 1'b1);
    repeat (20) @(posedge clock);
    check("lv locked", {progMode, entryPinGpioIn}, 2'b01);
    give_verdict;
  end
endmodule

// [sim/spme_programmer.sv]
// Programmer model: entry levels, link clock and its side of the data line.
// Assumes the bench resolves the data line from progDataOe.
`timescale 1ns/1ps
module spme_programmer (
  // System clock
  input wire clock,
  // Link to device
  output reg progClockPin = 1'b0,
  output reg pgData = 1'b0,
  output reg highEntryLevel = 1'b0,
  output reg lowVoltageEntryPin = 1'b0,
  input wire progDataIn
);
  // ------------------------------------------------
  // Link tasks, entered at a clock edge, 16 ns phases
  // ------------------------------------------------
  task automatic setEntry(input bit hv, input bit lv);
    pgData <= 1'b0;
    progClockPin <= 1'b0;
    @(posedge clock);
    highEntryLevel <= hv;
    lowVoltageEntryPin <= lv;
    @(posedge clock);
  endtask
  task automatic sendBit(input bit b);
    progClockPin <= 1'b1;
    pgData <= b;
    repeat (4) @(posedge clock);
    progClockPin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic sendCmd(input [5:0] c);
    int k;
    for (k = 0; k < 6; k++) sendBit(c[k]);
  endtask
  task automatic sendWord(input [13:0] d);
    int k;
    for (k = 0; k < 14; k++) sendBit(d[k]);
    pgData <= ~pgData;
  endtask
  task automatic getWord(output [13:0] d);
    int k;
    for (k = 0; k < 14; k++)
    begin
      progClockPin <= 1'b1;
      pgData <= ~pgData;
      repeat (4) @(posedge clock);
      progClockPin <= 1'b0;
      repeat (3) @(posedge clock);
      d[k] = progDataIn;
      @(posedge clock);
    end
  endtask
endmodule
